// file: rtl/buck_seq_defs.vh
// Timing counts and encodings for the buck startup and fault sequencer
`ifndef BUCK_SEQ_DEFS_VH
`define BUCK_SEQ_DEFS_VH
`define CLK_MHZ           125
`define ROLE_DETECT_US    50
`define ROLE_DETECT_CYC   (`ROLE_DETECT_US * `CLK_MHZ)
`define EDGE_WATCH_US     40
`define EDGE_WATCH_CYC    (`EDGE_WATCH_US * `CLK_MHZ)
`define PRESTART_US       400
`define PRESTART_CYC      (`PRESTART_US * `CLK_MHZ)
`define SOFTSTART_US      14000
`define SOFT_STEPS        32
`define STEP_CYC          ((`SOFTSTART_US * `CLK_MHZ) / `SOFT_STEPS)
`define NOM_HALF_CYC      833
`define MASTER_HALF_CYC   724
`define STEP_MAX          6'h20
`define STEP_ZERO         6'h00
`endif

// file: rtl/buck_startup_fault_sequencer.v
// Startup, soft-start/stop, role detection and feedback window supervision
`timescale 1ns/1ps
`default_nettype none
`include "buck_seq_defs.vh"

// Behaviour
// - Stay inactive until reset and lockout clear
// - Spend 50 us detecting master or slave
// - Without turn-on after detection, remain standby
// - Wait 400 us before soft-start begins
// - Clamp error amplifier low during pre-start
// - Raise reference 0 to 0.8 V, 32 steps
// - Whole soft-start ramp lasts 14 ms
// - Turn-on low starts 32-step soft-stop
// - Soft-stop ends with a high pulse of half the normal width
// - Reversals count from the current step
// - Probe pin current: master if above threshold
// - Master switches 15 percent faster
// - Master drives antiphase clock; slave locks
// - Edges within 40 us force slave role
// - Role held until power is cycled
// - Ignore comparators, flag low during soft-start
// - Below 0.6 V: undervoltage, flag low, restart
// - 0.60 to 0.72 V: low, flag low
// - 0.72 to 0.88 V: in window, flag released
// - 0.88 to 1.00 V: high, flag low
// - Above 1.0 V: latch off, switches off
module buck_startup_fault_sequencer #(
   parameter ROLE_CYC  = `ROLE_DETECT_CYC,
   parameter WATCH_CYC = `EDGE_WATCH_CYC,
   parameter PRE_CYC   = `PRESTART_CYC,
   parameter STEP_CYC  = `STEP_CYC
) (
   // Clock and power-on clear
   input  wire       clock,
   input  wire       rst_n,
   // Supply and turn-on request
   input  wire       supplyLowLockout,
   input  wire       turnOnRequest,
   // Frequency-lock pin and role probe
   input  wire       syncIn,
   input  wire       roleCurrentHigh,
   output reg        syncOut,
   output reg        syncOe,
   output reg        roleProbeOn,
   output reg        isMaster,
   // Feedback window comparators
   input  wire       outputOverLimit,
   input  wire       nearHigh,
   input  wire       nearLow,
   input  wire       outputUnderLimit,
   // Analog controls
   output reg  [5:0] refStep,
   output reg        ampClamp,
   output reg        prestartActive,
   output reg        highGate,
   output reg        switchEnable,
   // Status
   output reg        outputInWindowOe,
   output reg        faultLatched,
   output reg        undervoltage
);

   // One-hot states
   localparam S_LOCK  = 7'h01;
   localparam S_WATCH = 7'h02;
   localparam S_ROLE  = 7'h04;
   localparam S_IDLE  = 7'h08;
   localparam S_PRE   = 7'h10;
   localparam S_RAMP  = 7'h20;
   localparam S_RUN   = 7'h40;
   // Watch and role states are only reached again through reset,
   // so the role chosen at power-up cannot drift in service

   // Synchroniser stages: first rank read only by second
   reg [7:0]  syncA_reg;
   reg [7:0]  syncB_reg;
   reg        syncPrev_reg;             // Edge detector on clean pin
   reg [6:0]  state_reg;
   reg [20:0] timer_reg;                // Shared phase timer
   reg        stopping_reg;             // Down-counting soft-stop
   reg        lastPulse_reg;            // Final half pulse pending
   reg        pulseSeen_reg;            // Final pulse has begun
   reg [10:0] phase_reg;                // Switching half-period count
   reg        edgeSeen_reg;             // Pin edges seen in watch

   wire lockClean = syncB_reg[0];
   wire enClean   = syncB_reg[1];
   wire pinClean  = syncB_reg[2];
   wire ovClean   = syncB_reg[3];
   wire hiClean   = syncB_reg[4];
   wire loClean   = syncB_reg[5];
   wire uvClean   = syncB_reg[6];
   wire roleClean = syncB_reg[7];       // Probe current result
   wire pinEdge   = pinClean ^ syncPrev_reg;
   wire [10:0] halfCyc = isMaster ? 11'd`MASTER_HALF_CYC : 11'd`NOM_HALF_CYC;

   // Two-flop synchronisers for all asynchronous inputs
   // Both ranks reset with lockout asserted: a cleared first rank
   // would show a false lockout release right after reset
   always @(posedge clock) begin
      if (!rst_n) begin
         syncA_reg    <= 8'h01;
         syncB_reg    <= 8'h01;
         syncPrev_reg <= 1'b0;
      end else begin
         syncA_reg    <= {roleCurrentHigh, outputUnderLimit, nearLow, nearHigh,
                          outputOverLimit,
                          syncIn, turnOnRequest, supplyLowLockout};
         syncB_reg    <= syncA_reg;
         syncPrev_reg <= pinClean;
      end
   end

   // Sequencer: role detection, pre-start, soft ramps, supervision
   always @(posedge clock) begin
      if (!rst_n) begin
         state_reg     <= S_LOCK;
         timer_reg     <= 21'h000000;
         refStep       <= `STEP_ZERO;
         stopping_reg  <= 1'b0;
         lastPulse_reg <= 1'b0;
         pulseSeen_reg <= 1'b0;
         isMaster      <= 1'b0;
         edgeSeen_reg  <= 1'b0;
         faultLatched  <= 1'b0;
         undervoltage  <= 1'b0;
         roleProbeOn   <= 1'b0;
      end else begin
         undervoltage <= 1'b0;
         case (state_reg)
            S_LOCK: begin
               // Hold everything off while supply is low
               if (!lockClean) begin
                  state_reg <= S_WATCH;
                  timer_reg <= 21'h000000;
               end
            end
            S_WATCH: begin
               // Any edge from an outside source forces slave
               if (pinEdge)
                  edgeSeen_reg <= 1'b1;
               if (timer_reg >= WATCH_CYC - 1) begin
                  timer_reg   <= 21'h000000;
                  state_reg   <= S_ROLE;
                  roleProbeOn <= !(edgeSeen_reg || pinEdge);
               end else
                  timer_reg <= timer_reg + 21'h000001;
            end
            S_ROLE: begin
               // Probe runs for the detection window then decides once
               if (timer_reg >= ROLE_CYC - 1) begin
                  roleProbeOn <= 1'b0;
                  // Current result arrives two cycles late; window is long
                  isMaster    <= roleProbeOn && roleClean;
                  state_reg   <= S_IDLE;
                  timer_reg   <= 21'h000000;
               end else
                  timer_reg <= timer_reg + 21'h000001;
            end
            S_IDLE: begin
               // Standby with no switching until turn-on
               if (enClean && !faultLatched) begin
                  state_reg <= S_PRE;
                  timer_reg <= 21'h000000;
               end
            end
            S_PRE: begin
               // Boost charge and limit setting happen outside
               if (!enClean)
                  state_reg <= S_IDLE;
               else if (timer_reg >= PRE_CYC - 1) begin
                  state_reg    <= S_RAMP;
                  timer_reg    <= 21'h000000;
                  refStep      <= `STEP_ZERO;
                  stopping_reg <= 1'b0;
               end else
                  timer_reg <= timer_reg + 21'h000001;
            end
            S_RAMP: begin
               // Direction follows turn-on; reversal keeps the step
               stopping_reg <= !enClean;
               if (lastPulse_reg) begin
                  // Wait for a fresh final pulse, then for its end;
                  // a pulse already running is let finish first
                  if (highGate && phase_reg == 11'h000)
                     pulseSeen_reg <= 1'b1;
                  else if (pulseSeen_reg && !highGate) begin
                     lastPulse_reg <= 1'b0;
                     pulseSeen_reg <= 1'b0;
                     state_reg     <= S_IDLE;
                  end
               end else if (timer_reg >= STEP_CYC - 1) begin
                  timer_reg <= 21'h000000;
                  if (!enClean) begin
                     if (refStep == `STEP_ZERO)
                        lastPulse_reg <= 1'b1;
                     else
                        refStep <= refStep - 6'h01;
                  end else if (refStep == `STEP_MAX)
                     state_reg <= S_RUN;
                  else
                     refStep <= refStep + 6'h01;
               end else
                  timer_reg <= timer_reg + 21'h000001;
            end
            S_RUN: begin
               // Window supervision after soft-start
               if (ovClean) begin
                  faultLatched <= 1'b1;
                  state_reg    <= S_IDLE;
                  refStep      <= `STEP_ZERO;
               end else if (uvClean) begin
                  undervoltage <= 1'b1;
                  state_reg    <= S_PRE;
                  timer_reg    <= 21'h000000;
                  refStep      <= `STEP_ZERO;
               end else if (!enClean) begin
                  state_reg    <= S_RAMP;
                  timer_reg    <= 21'h000000;
               end
            end
            default: state_reg <= S_LOCK;
         endcase
         // Lockout returning drops switching; role and latch stay
         if (lockClean && state_reg != S_LOCK && state_reg != S_WATCH
             && state_reg != S_ROLE) begin
            state_reg     <= S_IDLE;
            refStep       <= `STEP_ZERO;
            lastPulse_reg <= 1'b0;           // No stale final pulse
            pulseSeen_reg <= 1'b0;
         end
      end
   end

   // Switching phase: master runs faster and drives the antiphase clock
   // The pin clock is registered, so it trails the gate by one cycle;
   // at these periods that offset is far below a degree of phase
   always @(posedge clock) begin
      if (!rst_n) begin
         phase_reg <= 11'h000;
         highGate  <= 1'b0;
         syncOut   <= 1'b0;
         syncOe    <= 1'b0;
      end else begin
         syncOe <= isMaster && state_reg != S_LOCK && state_reg != S_WATCH
                   && state_reg != S_ROLE;
         if (!switchEnable) begin
            phase_reg <= 11'h000;
            highGate  <= 1'b0;
         end else if (!isMaster && pinEdge && pinClean) begin
            // Slave restarts its period on each external rising edge
            phase_reg <= 11'h000;
            highGate  <= 1'b1;
         end else if (lastPulse_reg && pulseSeen_reg && highGate
                      && phase_reg >= {1'b0, halfCyc[10:1]} - 11'h001) begin
            phase_reg <= 11'h000;
            highGate  <= 1'b0;
         end else if (phase_reg >= halfCyc - 11'h001) begin
            phase_reg <= 11'h000;
            highGate  <= !highGate;
         end else
            phase_reg <= phase_reg + 11'h001;
         syncOut <= isMaster && switchEnable && !highGate;
      end
   end

   // Decoded controls and window flag
   // Registered one cycle behind the state, so the gate stops
   // two cycles after a fault is acted on; lockout clears switchEnable directly, so one cycle
   always @(posedge clock) begin
      if (!rst_n) begin
         ampClamp         <= 1'b0;
         prestartActive   <= 1'b0;
         switchEnable     <= 1'b0;
         outputInWindowOe <= 1'b0;
      end else begin
         ampClamp       <= state_reg == S_PRE;
         prestartActive <= state_reg == S_PRE;
         switchEnable   <= (state_reg == S_RAMP || state_reg == S_RUN)
                           && !faultLatched && !lockClean;
         // Open drain: enable means pulling low
         if (state_reg != S_RUN)
            outputInWindowOe <= 1'b1;
         else if (ovClean || uvClean)
            outputInWindowOe <= 1'b1;
         else if (hiClean || loClean)
            outputInWindowOe <= 1'b1;
         else
            outputInWindowOe <= 1'b0;
      end
   end

endmodule // buck_startup_fault_sequencer
`default_nettype wire

// file: bench/buck_seq_chk_sva.sv
// Port-level assertion checker for the buck startup and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module buck_seq_chk (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst_n,
   // Inputs watched
   input wire logic       supplyLowLockout,
   // Outputs watched
   input wire logic       syncOut,
   input wire logic       syncOe,
   input wire logic       roleProbeOn,
   input wire logic       isMaster,
   input wire logic [5:0] refStep,
   input wire logic       ampClamp,
   input wire logic       prestartActive,
   input wire logic       highGate,
   input wire logic       switchEnable,
   input wire logic       outputInWindowOe,
   input wire logic       faultLatched,
   input wire logic       undervoltage
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Restart goes back through the clamped pre-start
   sequence s_restart;
      ##[1:4] prestartActive ##1 ampClamp;
   endsequence
   property p_lockout_idle; supplyLowLockout [*6] |-> !switchEnable && !highGate; endproperty
   a_lockout_idle: assert property (p_lockout_idle) else $error("switching under lockout");
   property p_clamp; prestartActive |-> (ampClamp && refStep == 6'h00 && !switchEnable)
      ##1 !highGate; endproperty
   a_clamp: assert property (p_clamp) else $error("pre-start without clamp");
   property p_step; $changed(refStep) |-> refStep == $past(refStep) + 6'h01
      || refStep == $past(refStep) - 6'h01 || refStep == 6'h00; endproperty
   a_step: assert property (p_step) else $error("reference jumped");
   property p_ramp_flag; switchEnable && refStep != 6'h20 |-> outputInWindowOe; endproperty
   a_ramp_flag: assert property (p_ramp_flag) else $error("flag released in ramp");
   property p_ov_off; faultLatched |-> outputInWindowOe ##2 (!switchEnable && !highGate);
   endproperty
   a_ov_off: assert property (p_ov_off) else $error("switching while latched");
   property p_ov_hold; faultLatched |=> faultLatched; endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("latch released");
   property p_role_hold; isMaster |=> isMaster && !roleProbeOn; endproperty
   a_role_hold: assert property (p_role_hold) else $error("role changed");
   property p_master_clk; syncOe |-> isMaster
      && syncOut == ($past(switchEnable) && !$past(highGate)); endproperty
   a_master_clk: assert property (p_master_clk) else $error("bad master clock");
   property p_uv_restart; undervoltage |-> s_restart; endproperty
   a_uv_restart: assert property (p_uv_restart) else $error("no restart");
endmodule // buck_seq_chk
`default_nettype wire

// file: bench/buck_far_side.sv
// Far-side model: frequency-lock pin partner, master resistor, feedback comparators
`timescale 1ns/1ps
`default_nettype none
module buck_far_side (
   // Clock and scenario controls
   input  wire logic       clock,
   input  wire logic       extClkOn,
   input  wire logic       resistorFitted,
   input  wire logic [2:0] fbZone,
   // Device side of the pin
   input  wire logic       syncOut,
   input  wire logic       syncOe,
   input  wire logic       roleProbeOn,
   output var  logic       syncIn,
   output var  logic       roleCurrentHigh,
   output var  logic [3:0] cmp
);
   logic [2:0] div = 3'h0;  // Other converter's clock divider
   // Other converter runs its clock from power-up
   always @(posedge clock) begin
      div <= div + 3'h1;
   end
   // Pin level: device drive wins, else other clock, else resistor pulls low
   always_comb begin
      syncIn = syncOe ? syncOut : (extClkOn ? div[2] : 1'b0);
      roleCurrentHigh = roleProbeOn & resistorFitted;
      cmp = {fbZone == 3'h4, fbZone == 3'h3, fbZone == 3'h1, fbZone == 3'h0};
   end
endmodule // buck_far_side
`default_nettype wire

// file: bench/buck_startup_fault_sequencer_tb.sv
// Self-checking testbench for the buck startup and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module buck_startup_fault_sequencer_tb;
   localparam int PRE = 30;
   localparam int STEP = 10;
   logic clock = 1'b0, rst_n = 1'b0, lockout = 1'b1, turnOn = 1'b0;
   logic extClkOn = 1'b0, resistorFitted = 1'b1;
   logic [2:0] fbZone = 3'h2;
   logic [3:0] cmp;
   logic syncIn, roleCurrentHigh, syncOut, syncOe, roleProbeOn, isMaster;
   logic ampClamp, prestartActive, highGate, switchEnable, outputInWindowOe;
   logic faultLatched, undervoltage;
   logic [5:0] refStep;
   int nMismatch = 0, numChecks = 0, k;
   // 125 MHz clock
   always #4 clock = ~clock;
   buck_far_side far (.clock, .extClkOn, .resistorFitted, .fbZone, .syncOut, .syncOe,
      .roleProbeOn, .syncIn, .roleCurrentHigh, .cmp);
   buck_startup_fault_sequencer #(.ROLE_CYC(20), .WATCH_CYC(16), .PRE_CYC(PRE),
      .STEP_CYC(STEP)) uut (.clock, .rst_n, .supplyLowLockout(lockout),
      .turnOnRequest(turnOn), .syncIn, .roleCurrentHigh, .syncOut, .syncOe, .roleProbeOn,
      .isMaster, .outputOverLimit(cmp[3]), .nearHigh(cmp[2]), .nearLow(cmp[1]),
      .outputUnderLimit(cmp[0]), .refStep, .ampClamp, .prestartActive, .highGate,
      .switchEnable, .outputInWindowOe, .faultLatched, .undervoltage);
   task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Sample just after an edge so its updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic setOn(input logic v);
      @(posedge clock);
      turnOn <= v;
   endtask
   task automatic waitStep(input logic [5:0] v);
      for (k = 0; k < 2000 && refStep !== v; k++) cyc(1);
      check("refStep reached", v, refStep);
   endtask
   // Supply recycle: reset, lockout, then role detection
   task automatic powerUp(input logic ext, input logic res);
      @(posedge clock);
      rst_n <= 1'b0;
      lockout <= 1'b1;
      extClkOn <= ext;
      resistorFitted <= res;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      cyc(8);
      check("probe under lockout", 6'h00, {switchEnable, roleProbeOn, isMaster});
      @(posedge clock);
      lockout <= 1'b0;
      cyc(60);
      check("role", {5'h0, !ext && res}, {5'h0, isMaster});
      check("pin drive", {5'h0, !ext && res}, {5'h0, syncOe});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (40000) @(posedge clock);
      nMismatch++;
      finish_test;
   end
   initial begin
      void'($urandom(99055));
      powerUp(1'b0, 1'b1);
      check("standby", 6'h00, {5'h0, switchEnable});
      setOn(1'b1);
      cyc(5);
      check("clamp", 6'h01, {5'h0, ampClamp});
      waitStep(6'h0A);
      setOn(1'b0);
      cyc(3 * STEP);
      check("counting down", 6'h01, {5'h0, refStep < 6'h0A});
      setOn(1'b1);
      waitStep(6'h20);
      cyc(10);
      for (int i = 0; i < 12; i++) begin
         @(posedge clock);
         fbZone <= (i == 0) ? 3'h2 : 3'($urandom_range(3, 1));
         cyc(6);
         check("window flag", {5'h0, fbZone != 3'h2}, {5'h0, outputInWindowOe});
      end
      @(posedge clock);
      fbZone <= 3'h0;
      for (k = 0; k < 20 && undervoltage !== 1'b1; k++) cyc(1);
      check("undervoltage", 6'h01, {5'h0, undervoltage});
      @(posedge clock);
      fbZone <= 3'h2;
      for (k = 0; k < 2000 && refStep !== 6'h20; k++) cyc(1);
      check("ramp length", 6'h01, {5'h0, k >= PRE + 31 * STEP && k <= PRE + 34 * STEP + 10});
      setOn(1'b0);
      waitStep(6'h00);
      for (k = 0; k < 5000 && switchEnable !== 1'b0; k++) cyc(1);
      check("stopped", 6'h00, {5'h0, switchEnable});
      setOn(1'b1);
      waitStep(6'h20);
      @(posedge clock);
      fbZone <= 3'h4;
      cyc(8 + STEP);
      check("overvoltage", 6'h07, {3'h0, faultLatched, !switchEnable, outputInWindowOe});
      fbZone <= 3'h2;
      setOn(1'b0);
      setOn(1'b1);
      cyc(PRE + 20);
      check("still latched", 6'h01, {refStep[4:0], faultLatched});
      @(posedge clock);
      lockout <= 1'b1;
      cyc(10);
      check("role kept", 6'h01, {5'h0, isMaster});
      powerUp(1'b1, 1'b1);
      check("latch cleared", 6'h00, {5'h0, faultLatched});
      finish_test;
   end
endmodule // buck_startup_fault_sequencer_tb
bind buck_startup_fault_sequencer buck_seq_chk chk (.clock, .rst_n, .supplyLowLockout,
   .syncOut, .syncOe, .roleProbeOn, .isMaster, .refStep, .ampClamp, .prestartActive,
   .highGate, .switchEnable, .outputInWindowOe, .faultLatched, .undervoltage);
`default_nettype wire
